/* camts_pkg.sv */
// Purpose: Shared constants and types of the bus transfer sequencer
// Assumes: 32-bit address and data, byte strobe bit i = byte offset i
// Notes:   Response code is 3 bits wide, transfer kind 2 bits
package camts_pkg;
  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HRESP_OKAY    = 3'h0;
  localparam logic [2:0] HRESP_ERROR   = 3'h1;
  localparam logic [1:0] SIZE_BYTE     = 2'h0;
  localparam logic [1:0] SIZE_HALF     = 2'h1;
  localparam logic [1:0] SIZE_WORD     = 2'h2;
  localparam logic [3:0] STRB_ALL      = 4'hf;
  localparam logic [2:0] WORD_BYTES    = 3'h4;
  localparam logic [2:0] REM_THREE     = 3'h3;
  localparam logic [2:0] REM_TWO       = 3'h2;
  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ADDR     = 32'h0;
  localparam logic [31:0] RST_DATA     = 32'h0;
  localparam logic [3:0]  RST_STRB     = 4'h0;
  localparam int          BUF_DEPTH    = 2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PART_ALIGNED, PART_FIRST, PART_SECOND}
    camts_part_e;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata_lo;
    logic [31:0] wdata_hi;
  } camts_req_s;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [3:0]  strb;
    logic        unalign;
    logic [31:0] wdata;
  } camts_part_s;
endpackage

/* camts_buf.sv */
// Purpose: Small FIFO that decouples the request source from the bus
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Ready and valid come straight from flops
`timescale 1ns/1ps
module camts_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   CNT_MAX = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_MAX = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != CNT_MAX);
      out_valid <= (cnt_d != '0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_MAX) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_MAX) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // Storage needs no reset; valid is guarded by the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end
endmodule

/* camts_top.sv */
// Purpose: Master-side transfer sequencing on a pipelined bus
// Assumes: Slave logic on the same clock; HREADY high when bus idle
// Notes:   Items that cross a word edge are split into two portions
`timescale 1ns/1ps
module camts_top
  import camts_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  camts_req_s       REQ,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [1:0]       HSIZE,
  output logic [3:0]       HBSTRB,
  output logic             HUNALIGN,
  output logic [31:0]      HWDATA,
  input  wire logic        HREADY,
  input  wire logic [2:0]  HRESP,
  input  wire logic [31:0] HRDATA,
  output logic             RSP_VALID,
  output logic [31:0]      RSP_RDATA,
  output logic             RSP_ERR,
  output logic             RSP_LAST
);
  // ----------------------------------------------------------------
  // Request buffer
  // ----------------------------------------------------------------
  camts_req_s  head;
  logic        head_valid;
  logic        head_pop;

  camts_buf #(
    .W     ($bits(camts_req_s)),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk       (CLK),
    .rst_n     (RSTN),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   (REQ),
    .out_valid (head_valid),
    .out_ready (head_pop),
    .out_data  (head)
  );

  // ----------------------------------------------------------------
  // Split decode of the buffer head
  // ----------------------------------------------------------------
  // Lanes past the word edge go in a second portion at the next word
  logic [1:0]  item_size;
  logic [2:0]  nbytes;
  logic [2:0]  span;
  logic [2:0]  rem;
  logic        mis;
  camts_part_s first_p;
  camts_part_s second_p;

  assign item_size = (head.size > SIZE_WORD) ? SIZE_WORD : head.size;
  assign nbytes    = 3'(4'h1 << item_size);
  assign span      = 3'({1'b0, head.addr[1:0]}) + nbytes;
  assign mis       = (span > WORD_BYTES);
  assign rem       = span - WORD_BYTES;

  always_comb begin
    first_p.addr     = head.addr;
    first_p.write    = head.write;
    first_p.size     = item_size;
    first_p.wdata    = head.wdata_lo;
    first_p.unalign  = mis;
    if (mis) begin
      first_p.strb = 4'(STRB_ALL << head.addr[1:0]);
    end else begin
      first_p.strb = 4'(((5'h1 << nbytes) - 5'h1) << head.addr[1:0]);
    end
    second_p.addr    = {head.addr[31:2] + 30'h1, 2'h0};
    second_p.write   = head.write;
    second_p.wdata   = head.wdata_hi;
    second_p.strb    = 4'((5'h1 << rem) - 5'h1);
    second_p.unalign = (rem == REM_THREE);
    if (rem == REM_THREE) begin
      second_p.size = SIZE_WORD;
    end else if (rem == REM_TWO) begin
      second_p.size = SIZE_HALF;
    end else begin
      second_p.size = SIZE_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Address phase
  // ----------------------------------------------------------------
  // A pending request may only change once the bus moves on, so
  // the address stage reloads on ready or when it shows IDLE.
  camts_part_e part_q;
  camts_part_s split_q;
  logic        split_pend_q;
  logic        ap_busy;
  logic        accept;
  logic        load;
  logic        err_first;
  logic        retract;
  logic [31:0] ap_wdata_q;
  logic        dp_valid_q;
  logic        dp_write_q;
  logic        dp_last_q;

  assign ap_busy   = (HTRANS == HTRANS_NONSEQ);
  assign accept    = ap_busy & HREADY;
  assign load      = ~ap_busy | HREADY;
  assign err_first = dp_valid_q & ~HREADY & (HRESP == HRESP_ERROR);
  // Errored first portion: its second half is withdrawn, not issued
  assign retract   = err_first & ap_busy & (part_q == PART_SECOND);
  assign head_pop  = head_valid & load & ~split_pend_q & ~retract;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HTRANS     <= HTRANS_IDLE;
      HADDR      <= RST_ADDR;
      HWRITE     <= 1'b0;
      HSIZE      <= SIZE_BYTE;
      HBSTRB     <= RST_STRB;
      HUNALIGN   <= 1'b0;
      ap_wdata_q <= RST_DATA;
      part_q     <= PART_ALIGNED;
    end else if (retract) begin
      HTRANS <= HTRANS_IDLE;
      part_q <= PART_ALIGNED;
    end else if (load) begin
      if (split_pend_q) begin
        HTRANS     <= HTRANS_NONSEQ;
        HADDR      <= split_q.addr;
        HWRITE     <= split_q.write;
        HSIZE      <= split_q.size;
        HBSTRB     <= split_q.strb;
        HUNALIGN   <= split_q.unalign;
        ap_wdata_q <= split_q.wdata;
        part_q     <= PART_SECOND;
      end else if (head_valid) begin
        HTRANS     <= HTRANS_NONSEQ;
        HADDR      <= first_p.addr;
        HWRITE     <= first_p.write;
        HSIZE      <= first_p.size;
        HBSTRB     <= first_p.strb;
        HUNALIGN   <= first_p.unalign;
        ap_wdata_q <= first_p.wdata;
        part_q     <= mis ? PART_FIRST : PART_ALIGNED;
      end else begin
        // Address and attributes keep stale values while IDLE
        HTRANS <= HTRANS_IDLE;
        part_q <= PART_ALIGNED;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      split_pend_q <= 1'b0;
      split_q      <= '0;
    end else if (retract) begin
      split_pend_q <= 1'b0;
    end else if (load) begin
      if (split_pend_q) begin
        split_pend_q <= 1'b0;
      end else if (head_valid && mis) begin
        split_pend_q <= 1'b1;
        split_q      <= second_p;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data phase
  // ----------------------------------------------------------------
  // HWDATA moves only at a write acceptance, so it stands through
  // every wait state of that write without extra hold logic
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HWDATA     <= RST_DATA;
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_last_q  <= 1'b0;
    end else if (accept) begin
      dp_valid_q <= 1'b1;
      dp_write_q <= HWRITE;
      dp_last_q  <= (part_q != PART_FIRST);
      if (HWRITE) begin
        HWDATA <= ap_wdata_q;
      end
    end else if (HREADY) begin
      dp_valid_q <= 1'b0;
    end
  end

  // Read data is taken in the ready cycle; no stall on this side
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= RST_DATA;
      RSP_ERR   <= 1'b0;
      RSP_LAST  <= 1'b0;
    end else begin
      RSP_VALID <= dp_valid_q & HREADY;
      if (dp_valid_q && HREADY) begin
        RSP_RDATA <= dp_write_q ? RST_DATA : HRDATA;
        RSP_ERR   <= (HRESP != HRESP_OKAY);
        RSP_LAST  <= dp_last_q | (HRESP != HRESP_OKAY);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_wait_hold: assert property (ap_busy && !HREADY && !retract |=>
      ap_busy && $stable(HADDR) && $stable(HWRITE) && $stable(HSIZE)
      && $stable(HBSTRB) && $stable(ap_wdata_q))
    else $error("pending request changed during wait state");
  a_wdata_next: assert property (accept && HWRITE |=>
      HWDATA == $past(ap_wdata_q))
    else $error("write data not driven after acceptance");
  a_wdata_hold: assert property (dp_valid_q && dp_write_q && !HREADY
      |=> $stable(HWDATA))
    else $error("write data moved during wait state");
  a_idle_empty: assert property (load && !retract && !split_pend_q
      && !head_valid |=> HTRANS == HTRANS_IDLE)
    else $error("transfer kind not IDLE with nothing to do");
  a_split_next: assert property (accept && part_q == PART_FIRST |=>
      HTRANS == HTRANS_NONSEQ && HADDR[1:0] == 2'h0 &&
      HADDR[31:2] == $past(HADDR[31:2]) + 30'h1 &&
      HWRITE == $past(HWRITE))
    else $error("second portion not issued at next word");
  a_first_attr: assert property (ap_busy && part_q == PART_FIRST |->
      HUNALIGN && HSIZE != SIZE_BYTE &&
      HBSTRB == 4'(STRB_ALL << HADDR[1:0]))
    else $error("first portion attributes wrong");
  a_second_flag: assert property (ap_busy && part_q == PART_SECOND |->
      (HUNALIGN == (HBSTRB == 4'h7)) &&
      (HUNALIGN == (HSIZE == SIZE_WORD)))
    else $error("second portion flag or size wrong");
  a_aligned_flag: assert property (ap_busy && part_q == PART_ALIGNED
      |-> !HUNALIGN)
    else $error("aligned access shows misaligned flag");
  a_ready_rsp: assert property (dp_valid_q && !HREADY |=>
      !RSP_VALID ##0 (dp_valid_q || accept))
    else $error("access ended without ready");
  a_rsp_idle: assert property (!dp_valid_q |=> !RSP_VALID)
    else $error("response without a data phase");
  a_dp_end: assert property (dp_valid_q && HREADY && !accept |=>
      !dp_valid_q)
    else $error("data phase outlived its ready");
  a_rsp_pulse: assert property (dp_valid_q && HREADY |=> RSP_VALID)
    else $error("completed access gave no response");
  a_wait_flag: assert property (ap_busy && !HREADY && !retract |=>
      $stable(HUNALIGN) && $stable(part_q))
    else $error("pending flag or portion changed in wait state");

  // ----------------------------------------------------------------
  // Acceptance and sequencing
  // ----------------------------------------------------------------
  a_dp_follow: assert property (accept |=>
      dp_valid_q && (dp_write_q == $past(HWRITE)))
    else $error("accepted access has no data phase");
  a_idle_take: assert property (!ap_busy && head_valid &&
      !split_pend_q |=> ap_busy && (HADDR == $past(head.addr)))
    else $error("idle bus did not present waiting request");
  a_wdata_read: assert property (accept && !HWRITE |=>
      $stable(HWDATA))
    else $error("read acceptance disturbed write data");
  a_kind_legal: assert property (HTRANS == HTRANS_IDLE ||
      HTRANS == HTRANS_NONSEQ)
    else $error("transfer kind neither IDLE nor NONSEQ");
  a_one_pend: assert property (split_pend_q |->
      ap_busy && part_q == PART_FIRST)
    else $error("second portion pending without a first");
  // A first portion answered OKAY with no wait state does not close the item
  a_split_last: assert property (accept && part_q == PART_FIRST ##1
      dp_valid_q && HREADY && HRESP == HRESP_OKAY |=>
      RSP_VALID && !RSP_LAST)
    else $error("first portion marked as last");

  // ----------------------------------------------------------------
  // Attributes of each portion
  // ----------------------------------------------------------------
  a_load_dir: assert property (load && !retract && !split_pend_q &&
      head_valid |=> HWRITE == $past(head.write))
    else $error("direction differs from request");
  a_first_size: assert property (load && !retract && !split_pend_q &&
      head_valid && mis |=> part_q == PART_FIRST &&
      HSIZE == ($past(head.size[1]) ? SIZE_WORD : $past(head.size)))
    else $error("first portion size is not item size");
  // Second portion starts at lane 0, so its lanes follow from its size
  a_second_lanes: assert property (ap_busy && part_q == PART_SECOND
      |-> HADDR[1:0] == 2'h0 && HBSTRB == ((HSIZE == SIZE_BYTE) ? 4'h1 :
      (HSIZE == SIZE_HALF) ? 4'h3 : 4'h7))
    else $error("second portion lanes disagree with size");
  a_word_lanes: assert property (ap_busy && part_q == PART_ALIGNED &&
      HSIZE == SIZE_WORD |-> HBSTRB == STRB_ALL && HADDR[1:0] == 2'h0)
    else $error("aligned word strobes wrong");
  a_byte_lanes: assert property (ap_busy && HSIZE == SIZE_BYTE &&
      part_q == PART_ALIGNED |-> HBSTRB == 4'(4'h1 << HADDR[1:0]))
    else $error("byte strobe on wrong lane");

  c_mis_read:  cover property (accept && part_q == PART_FIRST &&
      !HWRITE ##1 accept && part_q == PART_SECOND);
  c_mis_write: cover property (accept && part_q == PART_FIRST &&
      HWRITE ##1 accept);
  c_rwr:       cover property (accept && !HWRITE ##1 accept && HWRITE
      ##1 accept && !HWRITE);
  c_wait:      cover property (ap_busy && !HREADY && dp_valid_q
      ##1 accept);
  c_split3:    cover property (ap_busy && part_q == PART_SECOND &&
      HUNALIGN);
endmodule

/* camts_slave.sv */
// Purpose: Behavioural bus slave with random wait states
// Assumes: One clock; a NONSEQ seen with HREADY high is taken
// Notes:   Never answers ERROR; HRDATA is junk outside read ready
`timescale 1ns/1ps
module camts_slave
  import camts_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [31:0] HADDR,
  input  wire logic [2:0]  WAIT_MAX,
  output logic             HREADY,
  output logic [2:0]       HRESP,
  output logic [31:0]      HRDATA
);
  logic        dp_q;
  logic        wr_q;
  logic [2:0]  cnt_q;
  logic [31:0] ad_q;
  logic [15:0] pat_q;
  int          w;
  assign HRESP = HRESP_OKAY;
  // Changing junk so stale read data can never pass for a match
  assign HRDATA = (dp_q && HREADY && !wr_q) ? (ad_q ^ 32'h3c5a96e1)
                                           : {pat_q, ~pat_q};
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dp_q   <= 1'b0;
      wr_q   <= 1'b0;
      cnt_q  <= 3'h0;
      ad_q   <= 32'h0;
      pat_q  <= 16'h0;
      HREADY <= 1'b1;
    end else begin
      pat_q <= pat_q + 16'h1;
      if (HREADY) begin
        // Idle bus is ready, so a new request goes at once
        if (HTRANS == HTRANS_NONSEQ) begin
          w = $urandom_range(int'(WAIT_MAX), 0);
          dp_q   <= 1'b1;
          wr_q   <= HWRITE;
          ad_q   <= HADDR;
          cnt_q  <= w[2:0];
          HREADY <= (w == 0);
        end else begin
          dp_q   <= 1'b0;
          HREADY <= 1'b1;
        end
      end else begin
        cnt_q  <= cnt_q - 3'h1;
        HREADY <= (cnt_q == 3'h1);
      end
    end
  end
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the bus transfer sequencer
// Assumes: Slave model answers OKAY with 0..WAIT_MAX wait states
// Notes:   Expected portions queued at request, checked on the bus
`timescale 1ns/1ps
module testbench
  import camts_pkg::*;
;
  typedef struct {
    logic [31:0] a;
    logic        w;
    logic [1:0]  s;
    logic [3:0]  b;
    logic        u;
    logic [31:0] d;
    logic [31:0] r;
    logic        l;
  } camts_tb_exp_s;
  logic          CLK, RSTN, REQ_VALID, REQ_READY, HWRITE, HUNALIGN;
  logic          HREADY, RSP_VALID, RSP_ERR, RSP_LAST, held, dp, saw_full;
  camts_req_s    REQ;
  logic [31:0]   HADDR, HWDATA, HRDATA, RSP_RDATA, held_a;
  logic [1:0]    HTRANS, HSIZE;
  logic [3:0]    HBSTRB;
  logic [2:0]    HRESP, wait_max;
  int            miscompares, n_checks, cyc, i;
  camts_tb_exp_s pq[$], rq[$], cur, e;

  camts_top dut (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ(REQ), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HBSTRB(HBSTRB), .HUNALIGN(HUNALIGN),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRESP(HRESP), .HRDATA(HRDATA),
    .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .RSP_ERR(RSP_ERR),
    .RSP_LAST(RSP_LAST));
  camts_slave slave (.CLK(CLK), .RSTN(RSTN), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HADDR(HADDR), .WAIT_MAX(wait_max),
    .HREADY(HREADY), .HRESP(HRESP), .HRDATA(HRDATA));

  initial CLK = 1'b0;
  always #20 CLK = ~CLK;

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (x !== g) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Driver: offer one item, queue its bus portions once taken
  // ----------------------------------------------------------------
  task automatic send(input logic [31:0] a, input logic [1:0] s,
                      input logic w);
    int n, off, rem, k;
    n = 1 << s;
    off = a[1:0];
    rem = off + n - 4;
    REQ = '{addr: a, write: w, size: s, wdata_lo: $urandom,
            wdata_hi: $urandom};
    REQ_VALID = 1'b1;
    @(posedge CLK);
    k = 0;
    while (!REQ_READY && k < 300) begin
      saw_full = 1'b1;
      @(posedge CLK);
      k++;
    end
    chk("ready wait", 0, k >= 300);
    // Queue a step after the edge so the monitor never races the push
    #1;
    e = '{a, w, s, 4'h0, 1'b0, REQ.wdata_lo, 32'h0, 1'b1};
    e.r = w ? 32'h0 : a ^ 32'h3c5a96e1;
    if (rem > 0) begin
      e.b = 4'hf << off;
      e.u = 1'b1;
      e.l = 1'b0;
      pq.push_back(e);
      e.a = {a[31:2] + 30'h1, 2'h0};
      e.s = (rem == 1) ? SIZE_BYTE : (rem == 2) ? SIZE_HALF : SIZE_WORD;
      e.b = (4'h1 << rem) - 4'h1;
      e.u = (rem == 3);
      e.d = REQ.wdata_hi;
      e.r = w ? 32'h0 : e.a ^ 32'h3c5a96e1;
      e.l = 1'b1;
    end else begin
      e.b = ((1 << n) - 1) << off;
    end
    pq.push_back(e);
  endtask

  task automatic drain(input string name);
    int k;
    REQ_VALID = 1'b0;
    k = 0;
    while ((pq.size() > 0 || dp || rq.size() > 0) && k < 300) begin
      @(posedge CLK);
      #1;
      k++;
    end
    chk("drain wait", 0, k >= 300);
    @(posedge CLK);
    chk("htrans idle", HTRANS_IDLE, HTRANS);
    chk("req ready", 1, REQ_READY);
    #1;
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Monitor: bus portions, write data, holds and responses
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  always @(posedge CLK) if (RSTN) begin
    if (RSP_VALID) begin
      if (rq.size() == 0) chk("rsp spurious", 0, 1);
      else begin
        e = rq.pop_front();
        chk("rsp rdata", e.r, RSP_RDATA);
        chk("rsp last/err", {e.l, 1'b0}, {RSP_LAST, RSP_ERR});
      end
    end
    if (dp && cur.w) chk("hwdata", cur.d, HWDATA);
    if (dp && HREADY) begin
      rq.push_back(cur);
      dp = 1'b0;
    end
    if (held) chk("held req", {HTRANS_NONSEQ, held_a[29:0]},
                  {HTRANS, HADDR[29:0]});
    if (HTRANS == HTRANS_NONSEQ && HREADY) begin
      if (pq.size() == 0) chk("bus spurious", 0, 1);
      else begin
        cur = pq.pop_front();
        dp = 1'b1;
        chk("haddr", cur.a, HADDR);
        chk("attrs", {cur.w, cur.s, cur.b, cur.u},
            {HWRITE, HSIZE, HBSTRB, HUNALIGN});
      end
    end else if (HREADY && pq.size() >= 3) chk("gap", 0, 1);
    held = (HTRANS == HTRANS_NONSEQ) && !HREADY;
    held_a = HADDR;
  end

  initial begin
    RSTN = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    wait_max = 3'h0;
    held = 1'b0;
    dp = 1'b0;
    saw_full = 1'b0;
    void'($urandom(32'h47b9d6a8));
    repeat (6) @(posedge CLK);
    #1 RSTN = 1'b1;
    send(32'h100, SIZE_WORD, 1'b0);
    REQ_VALID = 1'b0;
    @(posedge CLK);
    #1;
    chk("first accept", HTRANS_NONSEQ, HTRANS);
    drain("idle_first");
    // Every crossing case, back to back, then an aligned access
    for (i = 0; i < 8; i++)
      send(32'h40 * i + ((i % 4 == 0) ? 3 : i % 4),
           (i % 4 == 0) ? SIZE_HALF : SIZE_WORD, i[2]);
    send(32'h800, SIZE_WORD, 1'b0);
    drain("misaligned");
    for (int t = 0; t < 2; t++) begin
      wait_max = t ? 3'h7 : 3'h3;
      saw_full = 1'b0;
      for (i = 0; i < 30; i++) begin
        e.a = $urandom;
        e.s = $urandom_range(2, 0);
        if (e.s == SIZE_HALF && e.a[1:0] == 2'h1) e.a[0] = 1'b0;
        send(e.a, e.s, $urandom_range(1, 0));
      end
      drain(t ? "stall" : "random");
      chk("buffer refused", 1, saw_full);
    end
    end_of_test;
  end
endmodule
